// ### hdl/ripc_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module ripc_ctrl
  import ripc_pkg::*;
#(
  parameter int WAKE_CLKS = WAKE_MIN_CLKS
) (
  input  wire logic             clk_i,            // oscillator clock
  input  wire logic             srst_i,           // power-on reset, sync, high
  input  wire logic             rst_pin_i,        // external reset pin
  input  wire logic             bod_low_i,        // low-supply indication
  input  wire logic             ext0_pin_n_i,     // external interrupt 0 pin
  input  wire logic             ext1_pin_n_i,     // external interrupt 1 pin
  input  wire logic             ext0_level_i,     // ext0 in level mode
  input  wire logic             ext1_level_i,     // ext1 in level mode
  input  wire logic [NSRC-1:0]  irq_req_i,        // source requests, polling order
  input  wire logic [NSRC-1:0]  irq_en_i,         // per-source enables (brown-out unused)
  input  wire logic [2*NSRC-1:0] irq_prio_i,      // two priority bits per source
  input  wire logic             brownout_irq_enable_i, // enable bit of E8H register
  input  wire logic             soft_reset_bit_i, // soft reset control bit
  input  wire logic             watchdog_reset_status_i, // watchdog reset status
  input  wire logic             idle_set_i,       // software writes idle bit
  input  wire logic             powerdown_set_i,  // software writes power-down bit
  input  wire logic             pof_clear_i,      // software clears power-on flag
  input  wire logic             irq_ack_i,        // core starts serving vector
  output logic                  core_rst_o,       // full register reset to core
  output logic                  soft_rst_o,       // reset keeping soft bits
  output logic [15:0]           pc_load_o,        // address to fetch after event
  output logic                  pc_load_en_o,     // pc load strobe
  output logic                  pc_hold_o,        // program counter stopped
  output logic                  core_clk_en_o,    // core clock gate, low in power-down
  output logic                  irq_valid_o,      // interrupt pending to core
  output logic [15:0]           irq_vector_o,     // vector of winner
  output logic [1:0]            irq_level_o,      // priority level of winner
  output logic [7:0]            power_control_reg_o, // idle, pd and power-on flag
  output logic                  ale_o,            // address-latch strobe level
  output logic                  program_store_strobe_n_o, // program-store strobe level
  output logic                  strobe_weak_o,    // strobes driven weakly
  output logic                  soft_reset_keep_o,// soft reset bit kept through reset
  output logic                  watchdog_reset_status_keep_o       // watchdog status kept through soft reset
);
  localparam int RCW = $clog2(RST_MIN_CLKS + 1);
  localparam int WCW = $clog2(WAKE_CLKS + 1);
  localparam int BCW = $clog2(BOD_MIN_CLKS + 1);

  // elaboration guard: a zero wake count would let any pin glitch end power-down
  if (WAKE_CLKS < 1) begin : g_wake_check
    $error("WAKE_CLKS must be at least 1");
  end

  // vector table in polling order
  function automatic logic [15:0] src_vector(input int idx);
    unique case (idx)
      0:       src_vector = VEC_EXT0;
      1:       src_vector = VEC_BROWNOUT;
      2:       src_vector = VEC_TIMER0;
      3:       src_vector = VEC_EXT1;
      4:       src_vector = VEC_TIMER1;
      5:       src_vector = VEC_PCA;
      6:       src_vector = VEC_EXT2;
      7:       src_vector = VEC_EXT3;
      8:       src_vector = VEC_SERIAL; // uart and sync serial share this
      default: src_vector = VEC_TIMER2;
    endcase
  endfunction : src_vector

  // two-flop synchronisers for pins
  // nothing but sync2 reads sync1, so a metastable first stage never reaches logic
  logic [3:0] sync1, sync2;
  always_ff @(posedge clk_i) begin
    sync1 <= {bod_low_i, ext1_pin_n_i, ext0_pin_n_i, rst_pin_i};
    sync2 <= sync1;
  end
  logic rst_pin_s, ext0_n_s, ext1_n_s, bod_s;
  assign rst_pin_s = sync2[0];
  assign ext0_n_s  = sync2[1];
  assign ext1_n_s  = sync2[2];
  assign bod_s     = sync2[3];

  // state
  ripc_mode_e      mode, next_mode;
  logic [RCW-1:0]  rst_cnt, next_rst_cnt;
  logic [BCW-1:0]  bod_cnt, next_bod_cnt;
  logic [WCW-1:0]  wake_cnt, next_wake_cnt;
  logic            pin_rst, next_pin_rst;
  logic            swr_q, next_swr_q;
  logic            ebo_q, next_ebo_q;
  logic            power_on_flag, next_pof;
  logic            core_rst, next_core_rst;
  logic            soft_rst, next_soft_rst;
  logic [15:0]     pc_load, next_pc_load;
  logic            pc_load_en, next_pc_load_en;
  logic            irq_valid, next_irq_valid;
  logic [15:0]     irq_vector, next_irq_vector;
  logic [1:0]      irq_level, next_irq_level;
  logic            wake_irq, next_wake_irq;
  logic            watchdog_reset_status_keep, next_watchdog_reset_status_keep;

  logic bod_active, any_irq, wake_req;
  logic [NSRC-1:0] req_eff;
  int   win;

  // arbitration: highest level first, then fixed polling order
  always_comb begin
    req_eff = irq_req_i & irq_en_i;
    req_eff[SRC_BOD] = bod_active & brownout_irq_enable_i;
    if (mode == RIPC_PDOWN) begin
      req_eff = '0; // other sources frozen without a clock
    end
    win = NSRC;
    // levels are scanned from the top and sources upward, so the first hit wins;
    // a lower index is polled earlier and beats a later source on the same level
    // brown-out never comes from irq_req_i; its request is the filter output above
    for (int lvl = 3; lvl >= 0; lvl--) begin
      for (int s = 0; s < NSRC; s++) begin
        if (win == NSRC && req_eff[s] && irq_prio_i[2*s +: 2] == 2'(lvl)) begin
          win = s;
        end
      end
    end
    any_irq = (win != NSRC);
  end

  // wake source: enabled level-mode ext0/ext1 low
  // level mode is required: with the clock stopped there is nothing to latch an edge
  assign wake_req = (irq_en_i[SRC_EXT0] && ext0_level_i && !ext0_n_s) ||
                    (irq_en_i[SRC_EXT1] && ext1_level_i && !ext1_n_s);
  assign bod_active = (bod_cnt == BCW'(BOD_MIN_CLKS));

  // next-state for reset, brown-out, modes and interrupt request
  always_comb begin
    next_mode       = mode;
    next_rst_cnt    = rst_cnt;
    next_bod_cnt    = bod_cnt;
    next_wake_cnt   = wake_cnt;
    next_pin_rst    = pin_rst;
    next_swr_q      = soft_reset_bit_i;
    next_ebo_q      = brownout_irq_enable_i;
    next_pof        = power_on_flag;
    next_core_rst   = 1'b0;
    next_soft_rst   = 1'b0;
    next_pc_load    = pc_load;
    next_pc_load_en = 1'b0;
    next_irq_valid  = 1'b0;
    next_irq_vector = irq_vector;
    next_irq_level  = irq_level;
    next_wake_irq   = wake_irq && !irq_ack_i;

    // counted reset pin: glitches shorter than 24 clocks are ignored
    // the counter saturates, so a pin held high keeps the core in reset
    if (rst_pin_s) begin
      if (rst_cnt != RCW'(RST_MIN_CLKS)) next_rst_cnt = rst_cnt + 1'b1;
    end else begin
      next_rst_cnt = '0;
    end
    next_pin_rst = rst_pin_s && (rst_cnt == RCW'(RST_MIN_CLKS) ||
                                 rst_cnt == RCW'(RST_MIN_CLKS - 1));

    // brown-out filter
    // trade-off: the filter adds its full count of latency to every brown-out response
    if (bod_s) begin
      if (!bod_active) next_bod_cnt = bod_cnt + 1'b1;
    end else begin
      next_bod_cnt = '0;
    end

    // power-on flag: cleared only by software, survives pin resets
    if (pof_clear_i) next_pof = 1'b0;

    unique case (mode)
      RIPC_RUN: begin
        if (powerdown_set_i) next_mode = RIPC_PDOWN;
        else if (idle_set_i) next_mode = RIPC_IDLE;
      end
      RIPC_IDLE: begin
        if (any_irq) next_mode = RIPC_RUN; // any pending interrupt clears idle
      end
      RIPC_PDOWN: begin
        next_wake_cnt = '0;
        if (wake_req) next_mode = RIPC_WAKE;
      end
      RIPC_WAKE: begin
        // pin must stay low the full wake count before release completes it
        if (wake_req) begin
          if (wake_cnt != WCW'(WAKE_CLKS)) next_wake_cnt = wake_cnt + 1'b1;
        end else if (wake_cnt == WCW'(WAKE_CLKS)) begin
          next_mode = RIPC_RUN;
        end else begin
          next_mode = RIPC_PDOWN;
        end
      end
    endcase

    // interrupt presented only while the core runs or idles
    if ((mode == RIPC_RUN || mode == RIPC_IDLE) && any_irq && !irq_ack_i) begin
      next_irq_valid  = 1'b1;
      next_irq_vector = src_vector(win);
      next_irq_level  = irq_prio_i[2*win +: 2];
    end
    // the wake pin is already high again when the core gets here, so the wake
    // request is held on its own until the core takes it
    if (wake_irq && !irq_ack_i) begin
      next_irq_valid  = 1'b1;
      next_irq_vector = irq_vector;
      next_irq_level  = irq_level;
    end
    if (mode == RIPC_WAKE && next_mode == RIPC_RUN) begin
      next_wake_irq   = 1'b1;
      next_irq_valid  = 1'b1;
      next_irq_vector = (ext0_level_i && irq_en_i[SRC_EXT0]) ? VEC_EXT0 : VEC_EXT1;
      next_irq_level  = '0;
    end

    // reset sources, highest importance last
    // a soft reset reuses the pc reload path but never raises the full core reset
    if (soft_reset_bit_i && !swr_q) begin
      next_soft_rst = 1'b1; // keeps swr and watchdog_reset_status
    end
    if (bod_active && (!brownout_irq_enable_i || (ebo_q && !brownout_irq_enable_i))) begin
      next_core_rst = 1'b1; // also clear-while-active
    end
    if (next_pin_rst) begin
      next_core_rst = 1'b1; // hardware reset restarts from the reset vector; power-on flag is kept
      next_mode     = RIPC_RUN;
    end
    if (next_core_rst || next_soft_rst) begin
      next_pc_load    = VEC_RESET;
      next_pc_load_en = 1'b1;
      next_irq_valid  = 1'b0;
      next_wake_irq   = 1'b0;
      if (!next_pin_rst) next_mode = RIPC_RUN;
    end
    // watchdog status is reported as kept only alongside a soft reset
    next_watchdog_reset_status_keep = watchdog_reset_status_i && next_soft_rst;
  end

  // registers; RAM is outside and never touched by any reset here
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mode       <= RIPC_RUN;
      rst_cnt    <= '0;
      bod_cnt    <= '0;
      wake_cnt   <= '0;
      pin_rst    <= 1'b0;
      swr_q      <= 1'b0;
      ebo_q      <= 1'b0;
      power_on_flag        <= 1'b1; // set by initial power-up
      core_rst   <= 1'b1;
      soft_rst   <= 1'b0;
      pc_load    <= VEC_RESET;
      pc_load_en <= 1'b1;
      irq_valid  <= 1'b0;
      irq_vector <= VEC_RESET;
      irq_level  <= '0;
      wake_irq   <= 1'b0;
      watchdog_reset_status_keep  <= 1'b0;
    end else begin
      mode       <= next_mode;
      rst_cnt    <= next_rst_cnt;
      bod_cnt    <= next_bod_cnt;
      wake_cnt   <= next_wake_cnt;
      pin_rst    <= next_pin_rst;
      swr_q      <= next_swr_q;
      ebo_q      <= next_ebo_q;
      power_on_flag        <= next_pof;
      core_rst   <= next_core_rst;
      soft_rst   <= next_soft_rst;
      pc_load    <= next_pc_load;
      pc_load_en <= next_pc_load_en;
      irq_valid  <= next_irq_valid;
      irq_vector <= next_irq_vector;
      irq_level  <= next_irq_level;
      wake_irq   <= next_wake_irq;
      watchdog_reset_status_keep  <= next_watchdog_reset_status_keep;
    end
  end

  // registered pin and status outputs
  logic [7:0] next_power_control_reg;
  logic       next_ale, next_pss_n, next_weak, next_hold, next_clk_en;
  always_comb begin
    next_power_control_reg                = '0;
    next_power_control_reg[POWER_CONTROL_REG_IDLE_BIT] = (next_mode == RIPC_IDLE);
    next_power_control_reg[POWER_CONTROL_REG_PD_BIT]   = (next_mode == RIPC_PDOWN || next_mode == RIPC_WAKE);
    next_power_control_reg[POWER_CONTROL_REG_POF_BIT]  = next_pof;
    next_weak   = next_pin_rst || next_core_rst; // weak pull-up during reset
    next_ale    = !next_power_control_reg[POWER_CONTROL_REG_PD_BIT];       // low in power-down
    next_pss_n  = !next_power_control_reg[POWER_CONTROL_REG_PD_BIT];
    next_hold   = next_mode != RIPC_RUN;         // pc stopped
    next_clk_en = !next_power_control_reg[POWER_CONTROL_REG_PD_BIT];
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      power_control_reg_o      <= 8'(1 << POWER_CONTROL_REG_POF_BIT); // only the power-on flag set
      ale_o                    <= 1'b1;
      program_store_strobe_n_o <= 1'b1;
      strobe_weak_o            <= 1'b1;
      pc_hold_o                <= 1'b0;
      core_clk_en_o            <= 1'b1;
    end else begin
      power_control_reg_o      <= next_power_control_reg;
      ale_o                    <= next_ale;
      program_store_strobe_n_o <= next_pss_n;
      strobe_weak_o            <= next_weak;
      pc_hold_o                <= next_hold;
      core_clk_en_o            <= next_clk_en;
    end
  end

  assign core_rst_o        = core_rst;
  assign soft_rst_o        = soft_rst;
  assign pc_load_o         = pc_load;
  assign pc_load_en_o      = pc_load_en;
  assign irq_valid_o       = irq_valid;
  assign irq_vector_o      = irq_vector;
  assign irq_level_o       = irq_level;
  assign soft_reset_keep_o = swr_q;
  assign watchdog_reset_status_keep_o       = watchdog_reset_status_keep;
endmodule : ripc_ctrl
`default_nettype wire

// ### hdl/ripc_pkg.sv
package ripc_pkg;
  // clocking and timing
  localparam int          CLK_HZ            = 10_000_000;
  localparam int          CLKS_PER_MCYCLE   = 12;
  localparam int          RST_MIN_MCYCLES   = 2;
  localparam int          RST_MIN_CLKS      = RST_MIN_MCYCLES * CLKS_PER_MCYCLE;
  localparam int          BOD_MIN_CLKS      = 4;
  localparam int          WAKE_MIN_CLKS     = 1024;
  // vectors
  localparam logic [15:0] VEC_RESET         = 16'h0000;
  localparam logic [15:0] VEC_EXT0          = 16'h0003;
  localparam logic [15:0] VEC_TIMER0        = 16'h000B;
  localparam logic [15:0] VEC_EXT1          = 16'h0013;
  localparam logic [15:0] VEC_TIMER1        = 16'h001B;
  localparam logic [15:0] VEC_SERIAL        = 16'h0023;
  localparam logic [15:0] VEC_TIMER2        = 16'h002B;
  localparam logic [15:0] VEC_PCA           = 16'h0033;
  localparam logic [15:0] VEC_EXT2          = 16'h003B;
  localparam logic [15:0] VEC_EXT3          = 16'h0043;
  localparam logic [15:0] VEC_BROWNOUT      = 16'h004B;
  // source indices in polling order
  localparam int          NSRC              = 10;
  localparam int          SRC_EXT0          = 0;
  localparam int          SRC_BOD           = 1;
  localparam int          SRC_EXT1          = 3;
  // field positions
  localparam int          POWER_CONTROL_REG_IDLE_BIT     = 0;
  localparam int          POWER_CONTROL_REG_PD_BIT       = 1;
  localparam int          POWER_CONTROL_REG_POF_BIT      = 4;
  localparam int          SWR_BIT           = 1;
  localparam int          WATCHDOG_RESET_STATUS_BIT          = 2;
  localparam int          EBO_BIT           = 3;
  localparam logic [7:0]  EXT_IRQ_EN_ADDR   = 8'hE8;

  typedef enum logic [3:0] {
    RIPC_RUN   = 4'b0001,
    RIPC_IDLE  = 4'b0010,
    RIPC_PDOWN = 4'b0100,
    RIPC_WAKE  = 4'b1000
  } ripc_mode_e;
endpackage : ripc_pkg

// ### test/ripc_board.sv
`timescale 1ns/1ns
`default_nettype none
module ripc_board (
  input  wire logic        clk_i,        // oscillator clock
  input  wire logic        go_i,         // start a pulse
  input  wire logic        sel_i,        // 0 reset pin, 1 wake pin
  input  wire logic [10:0] len_i,        // pulse length in clocks
  output logic             rst_pin_o,    // reset pin level
  output logic             ext0_pin_n_o  // wake pin, low active
);
  logic [10:0] cnt = 11'h000;
  logic        sel = 1'b0;
  // pins move just after an edge, like board logic on the same oscillator
  always @(posedge clk_i) begin
    if (go_i) begin
      cnt <= len_i;
      sel <= sel_i;
    end else if (cnt != 11'h000) begin
      cnt <= cnt - 11'h001;
    end
  end
  // the bench picks the length; a short one is a deliberate bad pulse
  assign rst_pin_o    = (cnt != 11'h000) && !sel;
  assign ext0_pin_n_o = !((cnt != 11'h000) && sel);
endmodule : ripc_board
`default_nettype wire

// ### test/ripc_ctrl_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module ripc_ctrl_asserts
  import ripc_pkg::*;
(
  input wire logic        clk_i,                    // clock
  input wire logic        srst_i,                   // reset
  input wire logic        rst_pin_i,                // reset pin
  input wire logic        bod_low_i,                // low supply
  input wire logic        brownout_irq_enable_i,    // bod irq enable
  input wire logic        soft_reset_bit_i,         // soft reset bit
  input wire logic        idle_set_i,               // idle request
  input wire logic        powerdown_set_i,          // pd request
  input wire logic        pof_clear_i,              // flag clear
  input wire logic        core_rst_o,               // core reset
  input wire logic        soft_rst_o,               // soft reset
  input wire logic [15:0] pc_load_o,                // load address
  input wire logic        pc_load_en_o,             // load strobe
  input wire logic        pc_hold_o,                // pc stopped
  input wire logic        core_clk_en_o,            // clock gate
  input wire logic        irq_valid_o,              // irq pending
  input wire logic [15:0] irq_vector_o,             // vector
  input wire logic [7:0]  power_control_reg_o,      // power control
  input wire logic        ale_o,                    // latch strobe
  input wire logic        program_store_strobe_n_o, // store strobe
  input wire logic        strobe_weak_o             // weak drive
);
  logic [4:0] pin_hi;
  logic [4:0] next_pin_hi;
  logic [3:0] bod_hi;
  logic [3:0] next_bod_hi;
  // run lengths saturate so a long hold never wraps back onto the trigger value
  always_comb begin
    next_pin_hi = (srst_i || !rst_pin_i) ? 5'h00 : (&pin_hi ? pin_hi : pin_hi + 5'h01);
    next_bod_hi = (srst_i || !bod_low_i) ? 4'h0 : (&bod_hi ? bod_hi : bod_hi + 4'h1);
  end
  always_ff @(posedge clk_i) begin
    pin_hi <= next_pin_hi;
    bod_hi <= next_bod_hi;
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  pin_reset_a: assert property (pin_hi == 5'h1E |-> core_rst_o)
    else $error("long reset pin hold gave no core reset");
  rst_vector_a: assert property (core_rst_o |-> pc_load_en_o && pc_load_o == VEC_RESET)
    else $error("reset does not load address zero");
  rst_strobe_a: assert property (core_rst_o |-> ale_o && program_store_strobe_n_o && strobe_weak_o)
    else $error("strobes not weakly high in reset");
  pof_keep_a: assert property ($fell(power_control_reg_o[POWER_CONTROL_REG_POF_BIT]) |-> $past(pof_clear_i))
    else $error("power-on flag cleared without software");
  soft_edge_a: assert property ($rose(soft_reset_bit_i) |-> ##1 soft_rst_o)
    else $error("soft reset bit rise gave no soft reset");
  bod_reset_a: assert property (bod_hi == 4'h7 && !brownout_irq_enable_i |-> ##[0:3] core_rst_o)
    else $error("brown-out without enable gave no reset");
  bod_irq_a: assert property (bod_hi == 4'h7 && brownout_irq_enable_i
      |-> ##[0:3] (irq_valid_o && irq_vector_o == VEC_BROWNOUT))
    else $error("enabled brown-out gave no vector");
  idle_entry_a: assert property (idle_set_i && !powerdown_set_i && !core_rst_o && !irq_valid_o
      && power_control_reg_o[1:0] == 2'b00 |-> ##[1:2] (pc_hold_o && power_control_reg_o[POWER_CONTROL_REG_IDLE_BIT]))
    else $error("idle request did not stop the pc");
  wake_clear_a: assert property (irq_valid_o |-> power_control_reg_o[1:0] == 2'b00)
    else $error("mode bit still set while irq served");
  idle_strobe_a: assert property (power_control_reg_o[POWER_CONTROL_REG_IDLE_BIT] |-> ale_o && program_store_strobe_n_o)
    else $error("strobes not high in idle");
  pd_entry_a: assert property ($rose(power_control_reg_o[POWER_CONTROL_REG_PD_BIT])
      |-> !ale_o && !program_store_strobe_n_o && !core_clk_en_o)
    else $error("power-down entry left clock or strobes up");
  pd_block_a: assert property (power_control_reg_o[POWER_CONTROL_REG_PD_BIT] && !irq_valid_o |=> !irq_valid_o
      || irq_vector_o == VEC_EXT0 || irq_vector_o == VEC_EXT1)
    else $error("non-wake source answered in power-down");
  pd_wake_c: cover property (power_control_reg_o[POWER_CONTROL_REG_PD_BIT] ##[1:200] irq_valid_o);
  idle_c: cover property (pc_hold_o ##[1:20] irq_valid_o);
  soft_c: cover property (soft_rst_o);
endmodule : ripc_ctrl_asserts
bind ripc_ctrl ripc_ctrl_asserts i_ripc_ctrl_asserts (.*);
`default_nettype wire

// ### test/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import ripc_pkg::*;
  typedef struct packed {
    logic [NSRC-1:0]   req;
    logic [2*NSRC-1:0] prio;
    logic [15:0]       vec;
    logic [1:0]        lvl;
  } ripc_row_s;
  logic              clk_i = 1'b0, srst_i = 1'b1, bod_low_i = 1'b0, brownout_irq_enable_i = 1'b0;
  logic              ext0_level_i = 1'b1, ext1_level_i = 1'b1, soft_reset_bit_i = 1'b0;
  logic              watchdog_reset_status_i = 1'b1, idle_set_i = 1'b0, powerdown_set_i = 1'b0;
  logic              pof_clear_i = 1'b0, irq_ack_i = 1'b0, go = 1'b0, sel = 1'b0;
  logic [NSRC-1:0]   irq_req_i = '0, irq_en_i = '1;
  logic [2*NSRC-1:0] irq_prio_i = '0;
  logic [10:0]       len = 11'h000;
  logic              rst_pin, ext0_n, core_rst_o, soft_rst_o, pc_load_en_o, pc_hold_o;
  logic              core_clk_en_o, irq_valid_o, ale_o, program_store_strobe_n_o, strobe_weak_o;
  logic              soft_reset_keep_o, watchdog_reset_status_keep_o, seen_rst = 1'b0, seen_srst = 1'b0;
  logic              seen_watchdog_reset_status = 1'b0;
  logic [15:0]       pc_load_o, irq_vector_o;
  logic [1:0]        irq_level_o;
  logic [7:0]        power_control_reg_o;
  int                fail_count = 0, compares = 0;
  // polling order within a level, and a higher level beating earlier sources
  ripc_row_s rows [8] = '{
    '{10'h3FD, 20'h00000, VEC_EXT0, 2'h0}, '{10'h3FC, 20'h00000, VEC_TIMER0, 2'h0},
    '{10'h3F8, 20'h00000, VEC_EXT1, 2'h0}, '{10'h300, 20'h00000, VEC_SERIAL, 2'h0},
    '{10'h200, 20'h00000, VEC_TIMER2, 2'h0}, '{10'h3FD, 20'hC0000, VEC_TIMER2, 2'h3},
    '{10'h0C0, 20'h08000, VEC_EXT3, 2'h2}, '{10'h030, 20'h00400, VEC_PCA, 2'h1}};
  ripc_ctrl #(.WAKE_CLKS(8)) i_ripc_ctrl (.rst_pin_i(rst_pin), .ext0_pin_n_i(ext0_n),
    .ext1_pin_n_i(1'b1), .*);
  ripc_board i_ripc_board (.clk_i, .go_i(go), .sel_i(sel), .len_i(len), .rst_pin_o(rst_pin),
    .ext0_pin_n_o(ext0_n));
  // 10 MHz oscillator
  initial begin
    forever #50 clk_i = !clk_i;
  end
  // latch one-cycle reset pulses so a later look cannot miss them
  always @(posedge clk_i) begin
    if (core_rst_o) seen_rst <= 1'b1;
    if (soft_rst_o) seen_srst <= 1'b1;
    if (watchdog_reset_status_keep_o) seen_watchdog_reset_status <= 1'b1;
  end
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      fail_count++;
    end
  endtask : check
  task automatic give_verdict();
    if (fail_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict
  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask : tick
  task automatic pin_pulse(input logic s, input logic [10:0] n);
    sel = s;
    len = n;
    go = 1'b1;
    tick(1);
    go = 1'b0;
    tick(int'(n) + 6);
  endtask : pin_pulse
  task automatic bod_pulse(input int n);
    bod_low_i = 1'b1;
    tick(n);
    bod_low_i = 1'b0;
    tick(8);
  endtask : bod_pulse
  task automatic ack();
    irq_ack_i = 1'b1;
    irq_req_i = '0;
    tick(1);
    irq_ack_i = 1'b0;
    tick(1);
  endtask : ack
  initial begin
    tick(3);
    check("reset power_control_reg", 24'(power_control_reg_o), 24'h000010);
    check("reset pc", 24'({pc_load_en_o, pc_load_o}), 24'h010000);
    check("reset strobes", 24'({ale_o, program_store_strobe_n_o, strobe_weak_o}), 24'h7);
    srst_i = 1'b0;
    tick(2);
    foreach (rows[i]) begin
      irq_req_i = rows[i].req;
      irq_prio_i = rows[i].prio;
      tick(2);
      check("irq winner", 24'({irq_valid_o, irq_level_o, irq_vector_o}),
            24'({1'b1, rows[i].lvl, rows[i].vec}));
      ack();
    end
    irq_prio_i = '0;
    pof_clear_i = 1'b1;
    tick(1);
    pof_clear_i = 1'b0;
    tick(1);
    check("pof cleared", 24'(power_control_reg_o[POWER_CONTROL_REG_POF_BIT]), 24'h0);
    seen_rst = 1'b0;
    pin_pulse(1'b0, 11'd20);
    check("short pin pulse", 24'(seen_rst), 24'h0);
    pin_pulse(1'b0, 11'd40);
    check("long pin pulse", 24'({seen_rst, power_control_reg_o[POWER_CONTROL_REG_POF_BIT]}), 24'h2);
    soft_reset_bit_i = 1'b1;
    tick(4);
    check("soft reset", 24'({seen_srst, soft_reset_keep_o, seen_watchdog_reset_status}), 24'h7);
    soft_reset_bit_i = 1'b0;
    seen_rst = 1'b0;
    bod_pulse(3);
    check("bod dip", 24'(seen_rst), 24'h0);
    bod_pulse(10);
    check("bod reset", 24'(seen_rst), 24'h1);
    brownout_irq_enable_i = 1'b1;
    bod_low_i = 1'b1;
    tick(10);
    check("bod vector", 24'({irq_valid_o, irq_vector_o}), 24'({1'b1, VEC_BROWNOUT}));
    ack();
    seen_rst = 1'b0;
    brownout_irq_enable_i = 1'b0;
    tick(4);
    check("bod enable cleared", 24'(seen_rst), 24'h1);
    bod_low_i = 1'b0;
    tick(8);
    idle_set_i = 1'b1;
    tick(1);
    idle_set_i = 1'b0;
    tick(2);
    check("idle entry", 24'({pc_hold_o, power_control_reg_o[1:0], ale_o, program_store_strobe_n_o}),
          24'h17);
    irq_req_i = 10'h004;
    tick(2);
    check("idle exit", 24'({irq_valid_o, pc_hold_o, power_control_reg_o[0]}), 24'h4);
    ack();
    powerdown_set_i = 1'b1;
    tick(1);
    powerdown_set_i = 1'b0;
    tick(2);
    check("pd entry", 24'({power_control_reg_o[1:0], ale_o, program_store_strobe_n_o,
          core_clk_en_o}), 24'h10);
    irq_req_i = 10'h004;
    tick(4);
    check("pd refuse", 24'(irq_valid_o), 24'h0);
    irq_req_i = '0;
    pin_pulse(1'b1, 11'd14);
    repeat (40) if (!irq_valid_o) tick(1);
    check("pd wake", 24'({irq_valid_o, power_control_reg_o[1], irq_vector_o}),
          24'({2'b10, VEC_EXT0}));
    ack();
    give_verdict();
  end
  // the sequence needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge clk_i);
    fail_count++;
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
